// file: hdl/dma_region_regs.svh
`ifndef DMA_REGION_REGS_SVH
`define DMA_REGION_REGS_SVH

// ----------------------------------------------------------------------------
// Sizes
// ----------------------------------------------------------------------------
`define RG_NUM_REGIONS 4
`define RG_NUM_QUEUES 2
`define RG_QUEUE_DEPTH 16
`define RG_DMA_CHANNELS 64
`define RG_QUICK_CHANNELS 8

// ----------------------------------------------------------------------------
// Address map (byte addresses, 12-bit bus)
// ----------------------------------------------------------------------------
// Per-region enable block: 0x000 + region * 0x010.
`define RG_PAGE_CFG 4'h0
`define RG_SLOT_DRAE_LO 2'h0
`define RG_SLOT_DRAE_HI 2'h1
`define RG_SLOT_QRAE 2'h2
// Channel registers, global view at page 0x1, region views at page 0x2.
`define RG_PAGE_GLOBAL 4'h1
`define RG_PAGE_VIEW 4'h2
`define RG_REL_INTEN_LO 5'h00
`define RG_REL_INTEN_HI 5'h04
`define RG_REL_PEND_LO 5'h08
`define RG_REL_PEND_HI 5'h0c
`define RG_REL_QEVEN 5'h10
// Queue entries: 0x400 + queue * 0x040 + slot * 4.
`define RG_PAGE_QUEUE 4'h4

// ----------------------------------------------------------------------------
// Fields and reset values
// ----------------------------------------------------------------------------
`define RG_KIND_MSB 7
`define RG_KIND_LSB 6
`define RG_CHAN_MSB 5
`define RG_CHAN_LSB 0
`define RG_QRAE_RSVD 24'h000000
`define RG_RESET_WORD 32'h00000000
`define RG_RESET_BYTE 8'h00

`endif

// file: hdl/dma_region_pkg.sv
package dma_region_pkg;

    // Source of a queued event, as stored in an entry.
    typedef enum logic [1:0] {
        KIND_EXTERNAL = 2'h0,
        KIND_MANUAL = 2'h1,
        KIND_CHAIN = 2'h2,
        KIND_QUICK_AUTO = 2'h3
    } entry_event_kind_t;

    // One queue slot: kind in the upper bits, channel below.
    typedef struct packed {
        entry_event_kind_t kind;
        logic [5:0] chan;
    } queue_entry_t;

endpackage

// file: hdl/region_gate_if.sv
// Carries one region-view access between the register file and the gate.
interface region_gate_if;
    logic [31:0] mask; // Per-bit access enable of the region.
    logic [31:0] stored; // Current register contents.
    logic [31:0] wdata; // Data written by software.
    logic [31:0] rdata; // Gated read value.
    logic [31:0] merged; // Next value after a gated plain write.
    logic [31:0] clear_bits; // Bits a gated write-one-to-clear may clear.

    modport gate (input mask, input stored, input wdata,
                  output rdata, output merged, output clear_bits);
    modport user (output mask, output stored, output wdata,
                  input rdata, input merged, input clear_bits);
endinterface

// file: hdl/region_gate.sv
// Applies a region's per-bit access enables to one register access.
module region_gate (
    region_gate_if.gate g
);
    // Disabled bits read as zero.
    assign g.rdata = g.stored & g.mask;
    // Disabled bits keep their stored state on a write.
    assign g.merged = (g.stored & ~g.mask) | (g.wdata & g.mask);
    // A clear can only reach enabled bits.
    assign g.clear_bits = g.wdata & g.mask;
endmodule

// file: hdl/dma_region_access.sv
// Functional notes
// - Disabled channel bit: reads zero, writes ignored.
// - Enabled channel bit: normal read and write.
// - Only enabled channels feed region interrupt.
// - Low enable register: bit n governs channel n.
// - Quick enable bits 7-0; 31-8 read zero.
// - Quick enable gates region reads and writes.
// - Gating also covers byte-wide quick registers.
// - Sixteen read-only entries per queue, two queues.
// - Entry bits 7-6 give event kind.
// - Entry bits 5-0 channel; 31-8 zero.
// - Entry fields read-only, not reset.
`include "dma_region_regs.svh"

module dma_region_access
    import dma_region_pkg::*;
(
    input wire logic clk,
    input wire logic reset_n,
    input wire logic [11:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [31:0] reg_rdata,
    input wire logic [63:0] xfer_done,
    input wire logic enq_valid,
    input wire logic enq_queue,
    input wire logic [3:0] enq_slot,
    input wire logic [1:0] enq_kind,
    input wire logic [5:0] enq_chan,
    output logic [3:0] region_irq
);

    // ------------------------------------------------------------------------
    // Storage
    // ------------------------------------------------------------------------
    // Region enables, one set per shadow region.
    logic [31:0] drae_lo_r [`RG_NUM_REGIONS];
    logic [31:0] drae_hi_r [`RG_NUM_REGIONS];
    logic [7:0] qrae_r [`RG_NUM_REGIONS];
    // Channel registers that the region views expose.
    logic [63:0] int_en_r; // Completion interrupt enable per channel.
    logic [63:0] pend_r; // Sticky completion flags per channel.
    logic [63:0] pend_nxt; // Next value of the sticky flags.
    logic [7:0] qev_en_r; // Byte-wide quick-channel event enable.
    // Queue slots, deliberately left without reset.
    queue_entry_t entry_r [`RG_NUM_QUEUES][`RG_QUEUE_DEPTH];
    logic [31:0] rdata_nxt; // Read value for the current address.
    logic [3:0] irq_nxt; // Next region interrupt levels.

    // ------------------------------------------------------------------------
    // Address decode
    // ------------------------------------------------------------------------
    // True when the low offset of an address equals a given slot.
    function automatic logic rel_is(input logic [4:0] rel, input logic [4:0] off);
        return rel == off;
    endfunction

    wire [3:0] page = reg_addr[11:8];
    wire acc_cfg = (page == `RG_PAGE_CFG) && (reg_addr[7:6] == 2'h0);
    wire [1:0] cfg_region = reg_addr[5:4];
    wire [1:0] cfg_slot = reg_addr[3:2];
    wire acc_global = (page == `RG_PAGE_GLOBAL) && (reg_addr[7:5] == 3'h0);
    wire acc_view = (page == `RG_PAGE_VIEW) && !reg_addr[7];
    wire acc_chan = acc_global || acc_view;
    wire [1:0] view_region = reg_addr[6:5];
    wire [4:0] rel = reg_addr[4:0];
    wire acc_queue = (page == `RG_PAGE_QUEUE) && !reg_addr[7];
    wire q_sel = reg_addr[6];
    wire [3:0] q_slot = reg_addr[5:2];
    wire word_ok = reg_addr[1:0] == 2'h0;
    wire sel_inten_lo = rel_is(rel, `RG_REL_INTEN_LO);
    wire sel_inten_hi = rel_is(rel, `RG_REL_INTEN_HI);
    wire sel_pend_lo = rel_is(rel, `RG_REL_PEND_LO);
    wire sel_pend_hi = rel_is(rel, `RG_REL_PEND_HI);
    wire sel_qev = rel_is(rel, `RG_REL_QEVEN);
    wire chan_hit = acc_chan && word_ok &&
        (sel_inten_lo || sel_inten_hi || sel_pend_lo || sel_pend_hi || sel_qev);

    // ------------------------------------------------------------------------
    // Gating of channel register accesses
    // ------------------------------------------------------------------------
    // The global view is never gated, so its mask is all ones.
    wire [31:0] view_mask =
        (sel_inten_lo || sel_pend_lo) ? drae_lo_r[view_region] :
        (sel_inten_hi || sel_pend_hi) ? drae_hi_r[view_region] :
        {`RG_QRAE_RSVD, qrae_r[view_region]};
    wire [31:0] acc_mask = acc_view ? view_mask : 32'hffffffff;
    wire [31:0] chan_stored =
        sel_inten_lo ? int_en_r[31:0] :
        sel_inten_hi ? int_en_r[63:32] :
        sel_pend_lo ? pend_r[31:0] :
        sel_pend_hi ? pend_r[63:32] :
        {24'h000000, qev_en_r};

    region_gate_if gi ();
    assign gi.mask = acc_mask;
    assign gi.stored = chan_stored;
    assign gi.wdata = reg_wdata;

    region_gate u_gate (
        .g(gi.gate)
    );

    wire chan_wr = reg_wr && chan_hit;

    // ------------------------------------------------------------------------
    // Region enable registers
    // ------------------------------------------------------------------------
    // Plain read/write words; software owns them entirely.
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            for (int r = 0; r < `RG_NUM_REGIONS; r++) begin
                drae_lo_r[r] <= `RG_RESET_WORD;
                drae_hi_r[r] <= `RG_RESET_WORD;
                qrae_r[r] <= `RG_RESET_BYTE;
            end
        end else if (reg_wr && acc_cfg && word_ok) begin
            unique case (cfg_slot)
                `RG_SLOT_DRAE_LO: drae_lo_r[cfg_region] <= reg_wdata;
                `RG_SLOT_DRAE_HI: drae_hi_r[cfg_region] <= reg_wdata;
                `RG_SLOT_QRAE: qrae_r[cfg_region] <= reg_wdata[7:0];
                default: ; // Slot 3 is unmapped; the write is dropped.
            endcase
        end
    end

    // ------------------------------------------------------------------------
    // Channel registers behind the views
    // ------------------------------------------------------------------------
    // Writes use the gated merge so that disabled bits are untouched.
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            int_en_r <= 64'h0;
            qev_en_r <= `RG_RESET_BYTE;
        end else if (chan_wr) begin
            if (sel_inten_lo) begin
                int_en_r[31:0] <= gi.merged;
            end
            if (sel_inten_hi) begin
                int_en_r[63:32] <= gi.merged;
            end
            if (sel_qev) begin
                qev_en_r <= gi.merged[7:0];
            end
        end
    end

    // Completion flags are write-one-to-clear; a new completion in the
    // same cycle as its clear wins, so no event is ever lost.
    wire [63:0] pend_clr = {(chan_wr && sel_pend_hi) ? gi.clear_bits : 32'h0,
                            (chan_wr && sel_pend_lo) ? gi.clear_bits : 32'h0};
    assign pend_nxt = (pend_r & ~pend_clr) | xfer_done;

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            pend_r <= 64'h0;
        end else begin
            pend_r <= pend_nxt;
        end
    end

    // ------------------------------------------------------------------------
    // Region completion interrupts
    // ------------------------------------------------------------------------
    // A channel counts toward a region only while that region owns it.
    always_comb begin
        for (int r = 0; r < `RG_NUM_REGIONS; r++) begin
            irq_nxt[r] = |(pend_r & int_en_r & {drae_hi_r[r], drae_lo_r[r]});
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            region_irq <= 4'h0;
        end else begin
            region_irq <= irq_nxt;
        end
    end

    // ------------------------------------------------------------------------
    // Event queue entries
    // ------------------------------------------------------------------------
    // Only the queue manager writes slots; software has no write path.
    // No reset: contents are undefined until the first event lands.
    always_ff @(posedge clk) begin
        if (enq_valid) begin
            entry_r[enq_queue][enq_slot] <= '{kind: entry_event_kind_t'(enq_kind),
                                              chan: enq_chan};
        end
    end

    wire queue_entry_t rd_entry = entry_r[q_sel][q_slot];

    // ------------------------------------------------------------------------
    // Read path
    // ------------------------------------------------------------------------
    // Unmapped or misaligned reads return zero.
    always_comb begin
        rdata_nxt = 32'h0;
        if (acc_cfg && word_ok) begin
            unique case (cfg_slot)
                `RG_SLOT_DRAE_LO: rdata_nxt = drae_lo_r[cfg_region];
                `RG_SLOT_DRAE_HI: rdata_nxt = drae_hi_r[cfg_region];
                `RG_SLOT_QRAE: rdata_nxt = {`RG_QRAE_RSVD, qrae_r[cfg_region]};
                default: rdata_nxt = 32'h0;
            endcase
        end else if (chan_hit) begin
            rdata_nxt = gi.rdata;
        end else if (acc_queue && word_ok) begin
            rdata_nxt = {24'h000000, rd_entry};
        end
    end

    // Read data is held only for the cycle after the strobe.
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            reg_rdata <= 32'h0;
        end else begin
            reg_rdata <= reg_rd ? rdata_nxt : 32'h0;
        end
    end

    // ------------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (!reset_n);

    sequence s_view_read_lo;
        reg_rd && acc_view && word_ok && sel_inten_lo;
    endsequence

    property p_read_masked;
        s_view_read_lo |=> ((reg_rdata & ~$past(drae_lo_r[view_region])) == 32'h0);
    endproperty
    a_read_masked: assert property (p_read_masked) else $error("disabled bit read nonzero");

    property p_write_pass;
        reg_wr && acc_view && word_ok && sel_inten_lo |=>
            int_en_r[31:0] == (($past(int_en_r[31:0]) & ~$past(drae_lo_r[view_region]))
                               | ($past(reg_wdata) & $past(drae_lo_r[view_region])));
    endproperty
    a_write_pass: assert property (p_write_pass) else $error("gated write wrong");

    property p_irq_owned;
        region_irq[1] |-> $past(|(pend_r & int_en_r & {drae_hi_r[1], drae_lo_r[1]}));
    endproperty
    a_irq_owned: assert property (p_irq_owned) else $error("irq without owned channel");

    property p_drae_lo_store;
        reg_wr && acc_cfg && word_ok && cfg_slot == `RG_SLOT_DRAE_LO && cfg_region == 2'h1
            |=> drae_lo_r[1] == $past(reg_wdata);
    endproperty
    a_drae_lo_store: assert property (p_drae_lo_store) else $error("low enable not stored");

    property p_drae_hi_read;
        reg_rd && acc_cfg && word_ok && cfg_slot == `RG_SLOT_DRAE_HI
            |=> reg_rdata == $past(drae_hi_r[cfg_region]);
    endproperty
    a_drae_hi_read: assert property (p_drae_hi_read) else $error("high enable read wrong");

    property p_qrae_rsvd;
        reg_rd && acc_cfg && word_ok && cfg_slot == `RG_SLOT_QRAE |=> reg_rdata[31:8] == 24'h0;
    endproperty
    a_qrae_rsvd: assert property (p_qrae_rsvd) else $error("quick enable reserved set");

    property p_quick_hold;
        reg_wr && acc_view && word_ok && sel_qev && !qrae_r[view_region][7]
            |=> qev_en_r[7] == $past(qev_en_r[7]);
    endproperty
    a_quick_hold: assert property (p_quick_hold) else $error("disabled quick bit changed");

    property p_entry_read;
        reg_rd && acc_queue && word_ok |=>
            reg_rdata == {24'h0, $past(entry_r[q_sel][q_slot])};
    endproperty
    a_entry_read: assert property (p_entry_read) else $error("queue entry read wrong");

    // A pending bit that the region does not own must survive a clear through its view.
    property p_clear_kept;
        reg_wr && acc_view && word_ok && sel_pend_lo |=>
            ((pend_r[31:0] & $past(pend_r[31:0] & ~drae_lo_r[view_region]))
             == $past(pend_r[31:0] & ~drae_lo_r[view_region]));
    endproperty
    a_clear_kept: assert property (p_clear_kept) else $error("disabled bit cleared");

    // The byte-wide quick register is masked by the quick enables on a view read.
    property p_quick_read;
        reg_rd && acc_view && word_ok && sel_qev |=>
            reg_rdata == {24'h0, $past(qev_en_r & qrae_r[view_region])};
    endproperty
    a_quick_read: assert property (p_quick_read) else $error("quick view read wrong");

    // A software write to a queue slot is a write to nothing; only an event may land.
    sequence s_entry_poke;
        reg_wr && acc_queue && word_ok && !enq_valid;
    endsequence

    property p_entry_hold;
        s_entry_poke |=>
            entry_r[$past(q_sel)][$past(q_slot)] == $past(entry_r[q_sel][q_slot]);
    endproperty
    a_entry_hold: assert property (p_entry_hold) else $error("queue slot changed by write");

endmodule

// file: verification/dma_region_access_tb.sv
module dma_region_access_tb;
    timeunit 1ns;
    timeprecision 1ps;
    import dma_region_pkg::*;

    // ------------------------------------------------------------------
    // Signals
    // ------------------------------------------------------------------
    logic clk; // Free-running 100 MHz clock.
    logic reset_n; // Asynchronous reset, active low.
    logic [11:0] reg_addr; // Register byte address.
    logic [31:0] reg_wdata; // Register write data.
    logic reg_wr; // Write strobe.
    logic reg_rd; // Read strobe.
    logic [31:0] reg_rdata; // Read data, one cycle after the strobe.
    logic [63:0] xfer_done; // Completion pulses per channel.
    logic enq_valid; // Queue slot write strobe.
    logic enq_queue; // Target queue.
    logic [3:0] enq_slot; // Target slot.
    logic [1:0] enq_kind; // Event kind of the entry.
    logic [5:0] enq_chan; // Channel number of the entry.
    logic [3:0] region_irq; // Per-region completion interrupt.
    logic [31:0] rv; // Last value read.
    int n_errors; // Mismatches seen.
    int tests_run; // Comparisons made.
    int cycles; // Clock cycles since start.

    dma_region_access dma_region_access_i (
        .clk(clk), .reset_n(reset_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .xfer_done(xfer_done),
        .enq_valid(enq_valid), .enq_queue(enq_queue), .enq_slot(enq_slot),
        .enq_kind(enq_kind), .enq_chan(enq_chan), .region_irq(region_irq)
    );

    // ------------------------------------------------------------------
    // Clock and watchdog
    // ------------------------------------------------------------------
    // The clock flips every half period of 5 ns.
    always #5 clk = ~clk;

    // The whole run needs about 120 cycles, so 5000 means a hang.
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 5000) begin
            n_errors = n_errors + 1;
            close_out();
        end
    end

    // ------------------------------------------------------------------
    // Tasks
    // ------------------------------------------------------------------
    // Compares a seen value with its expectation and counts the result.
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        tests_run = tests_run + 1;
        if (seen !== exp) begin
            n_errors = n_errors + 1;
            $display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    // One-cycle write; the idle cycle after it keeps strobes apart.
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        @(posedge clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask

    // One-cycle read; data are taken in the single cycle they stand.
    task automatic rd(input logic [11:0] a);
        @(posedge clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk);
        reg_rd <= 1'b0;
        #1;
        rv = reg_rdata;
    endtask

    // Pulses one completion bit and waits until the interrupt has settled.
    task automatic done_pulse(input int n);
        @(posedge clk);
        xfer_done <= 64'h1 << n;
        @(posedge clk);
        xfer_done <= 64'h0;
        repeat (2) @(posedge clk);
        #1;
    endtask

    // Writes one queue slot as the queue manager would.
    task automatic enq(input logic q, input logic [3:0] s, input logic [1:0] k,
                       input logic [5:0] c);
        @(posedge clk);
        enq_valid <= 1'b1;
        enq_queue <= q;
        enq_slot <= s;
        enq_kind <= k;
        enq_chan <= c;
        @(posedge clk);
        enq_valid <= 1'b0;
    endtask

    // Prints the counts and the verdict, then ends the run.
    task automatic close_out();
        $display("errors %0d comparisons %0d", n_errors, tests_run);
        if (n_errors == 0 && tests_run > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    // ------------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------------
    initial begin
        logic [11:0] qa;
        logic [5:0] ch;
        clk = 1'b0;
        reset_n = 1'b0;
        {reg_addr, reg_wdata, reg_wr, reg_rd, xfer_done} = '0;
        {enq_valid, enq_queue, enq_slot, enq_kind, enq_chan} = '0;
        n_errors = 0;
        tests_run = 0;
        cycles = 0;
        repeat (5) @(posedge clk);
        reset_n <= 1'b1;
        // Enables come out of reset cleared.
        rd(12'h000); check(rv, 32'h0);
        rd(12'h004); check(rv, 32'h0);
        rd(12'h038); check(rv, 32'h0);
        // Region 1 owns channels 4-7, 32 and 63; reserved quick bits stay zero.
        wr(12'h010, 32'h000000f0);
        wr(12'h014, 32'h80000001);
        wr(12'h018, 32'hffffffff);
        rd(12'h010); check(rv, 32'h000000f0);
        rd(12'h018); check(rv, 32'h000000ff);
        wr(12'h028, 32'h0000000f);
        // Region view of the low and high interrupt enables.
        wr(12'h100, 32'hffffffff);
        wr(12'h104, 32'hffffffff);
        rd(12'h220); check(rv, 32'h000000f0);
        rd(12'h224); check(rv, 32'h80000001);
        wr(12'h220, 32'h0);
        wr(12'h224, 32'h0);
        rd(12'h100); check(rv, 32'hffffff0f);
        rd(12'h104); check(rv, 32'h7ffffffe);
        // Byte-wide quick register seen through region 2 with half the enables.
        wr(12'h110, 32'h000000ff);
        rd(12'h250); check(rv, 32'h0000000f);
        wr(12'h250, 32'h0);
        rd(12'h110); check(rv, 32'h000000f0);
        // Interrupts: channel 3 belongs to no region, channels 5 and 32 to region 1.
        wr(12'h100, 32'hffffffff);
        wr(12'h104, 32'hffffffff);
        done_pulse(3);
        check({28'h0, region_irq}, 32'h0);
        rd(12'h228); check(rv, 32'h0);
        wr(12'h228, 32'h00000008);
        rd(12'h108); check(rv, 32'h00000008);
        done_pulse(5);
        check({28'h0, region_irq}, 32'h2);
        wr(12'h228, 32'h00000020);
        repeat (2) @(posedge clk);
        #1;
        check({28'h0, region_irq}, 32'h0);
        done_pulse(32);
        check({28'h0, region_irq}, 32'h2);
        wr(12'h22c, 32'h00000001);
        rd(12'h10c); check(rv, 32'h0);
        // Queue entries: every kind, both queues, first and last slot.
        for (int k = 0; k < 4; k++) begin
            ch = (k == 3) ? 6'h07 : 6'h3f - 6'(k);
            qa = 12'h400 + 12'(k % 2) * 12'h040 + 12'(k * 5) * 12'h004;
            enq(1'(k % 2), 4'(k * 5), 2'(k), ch);
            rd(qa); check(rv, {24'h0, 2'(k), ch});
            wr(qa, 32'hffffffff);
            rd(qa); check(rv, {24'h0, 2'(k), ch});
        end
        enq(1'b1, 4'hf, 2'h1, 6'h2a);
        enq(1'b0, 4'hf, 2'h3, 6'h03);
        rd(12'h47c); check(rv, 32'h0000006a);
        rd(12'h43c); check(rv, 32'h000000c3);
        // Unmapped place reads zero and drops writes.
        wr(12'h00c, 32'hffffffff);
        rd(12'h00c); check(rv, 32'h0);
        close_out();
    end
endmodule
